// [src/mqfc_core.sv]
// Functional notes
// - One to eight queues share a single memory pool.
// - Queue storage is whole 512x18 blocks, assigned at master reset.
// - Writes go to the write-selected queue, reads from the read-selected one.
// - Write and read ports act independently, same or different queue.
// - One write and one read accepted every cycle, no idle cycles.
// - Full flag follows write queue; output valid follows read queue.
// - Per-queue almost-full/almost-empty thresholds, shown on two 8-bit buses.
// - Write and read widths each selectable as 9 or 18 bits.
// - Width conversion is little-endian: low half travels first.
// - Width settings are global to all queues.
// - Without programming, eight equal queues are used.
// - Master reset captures setup pins and applies programming written before it, unless it oversizes the pool.
// - Partial reset clears one queue only if selected on both ports.
// - Read port works first-word-fall-through.
// - Selecting a queue falls its next word through; later words need read.
// - Switching to an empty queue keeps the last output word.
// - Writes to a full queue store nothing.
// - Only configured queues drive status bus bits.
`timescale 1ns/1ps
module mqfc_core (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire logic wide_in_sel_i,
  input wire logic wide_out_sel_i,
  input wire mqfc_pkg::mqfc_wr_t wr_port_i,
  input wire mqfc_pkg::mqfc_rd_t rd_port_i,
  output logic [mqfc_pkg::WW-1:0] read_data_o,
  output logic output_valid_flag_o,
  output logic queue_full_flag_o,
  output logic almost_full_flag_o,
  output logic almost_empty_flag_o,
  output logic [mqfc_pkg::QN-1:0] almost_full_status_bus_o,
  output logic [mqfc_pkg::QN-1:0] almost_empty_status_bus_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  import mqfc_pkg::*;

  // Live and shadow queue setup
  mqfc_qcfg_t qcfg_r [QN];
  mqfc_qcfg_t qsh_r [QN];
  logic [QW-1:0] qcnt_r;
  logic [QW-1:0] qcnt_sh_r;
  logic wide_in_r;
  logic wide_out_r;
  logic cfg_err_r;
  logic mrst;
  logic [BW+3:0] base [QN+1];
  logic [BW+3:0] sh_sum [QN+1];
  logic [CW-1:0] depth [QN];
  // Per-queue pointers and word counts
  logic [AW-1:0] wp_r [QN];
  logic [AW-1:0] rp_r [QN];
  logic [CW-1:0] cnt_r [QN];
  logic [QN-1:0] full;
  logic [QN-1:0] afl;
  logic [QN-1:0] ael;
  // Shared pool of 18-bit words
  logic [WW-1:0] mem [MEM_WORDS];
  logic [QW-1:0] wq_r;
  logic [QW-1:0] rq_r;
  logic pend_r;
  logic [HW-1:0] lo_r;
  logic wr_ok;
  logic wr_fire;
  logic [WW-1:0] wr_word;
  logic [WW-1:0] rd_word;
  logic [HW-1:0] hi_r;
  logic half_r;
  logic valid_r;
  logic [WW-1:0] data_r;
  logic consume;
  logic fetch;
  logic prst_hit;
  // Register bus state
  logic pready_r;
  logic [31:0] prdata_r;
  logic acc;
  logic hit;
  logic [31:0] rd_val;

  // Master reset is a level, active low
  assign mrst = !master_reset_n_i;
  assign prst_hit = !partial_reset_n_i && (wq_r == rq_r);

  // Block bases as running sums over active queues
  assign base[0] = '0;
  assign sh_sum[0] = '0;
  for (genvar q = 0; q < QN; q++) begin : g_q
    assign base[q+1] = base[q] + ((q <= int'(qcnt_r)) ? (BW+4)'(qcfg_r[q].blocks) : '0);
    assign sh_sum[q+1] = sh_sum[q] + ((q <= int'(qcnt_sh_r)) ? (BW+4)'(qsh_r[q].blocks) : '0);
    assign depth[q] = (q <= int'(qcnt_r)) ? CW'({qcfg_r[q].blocks, 9'h000}) : '0;
    assign full[q] = (cnt_r[q] == depth[q]);
    assign afl[q] = (depth[q] - cnt_r[q]) <= CW'(qcfg_r[q].af);
    assign ael[q] = cnt_r[q] <= CW'(qcfg_r[q].ae);
    assign almost_full_status_bus_o[q] = (q <= int'(qcnt_r)) && afl[q];
    assign almost_empty_status_bus_o[q] = (q <= int'(qcnt_r)) && ael[q];

    // Per-queue pointers and level
    always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
        wp_r[q] <= '0;
        rp_r[q] <= '0;
        cnt_r[q] <= '0;
      end else if (mrst || (prst_hit && wq_r == QW'(q))) begin
        wp_r[q] <= '0;
        rp_r[q] <= '0;
        cnt_r[q] <= '0;
      end else begin
        if (wr_fire && wq_r == QW'(q)) begin
          wp_r[q] <= (CW'(wp_r[q]) == depth[q] - 1'b1) ? '0 : wp_r[q] + 1'b1;
        end
        if (fetch && rq_r == QW'(q)) begin
          rp_r[q] <= (CW'(rp_r[q]) == depth[q] - 1'b1) ? '0 : rp_r[q] + 1'b1;
        end
        cnt_r[q] <= cnt_r[q] + CW'(wr_fire && wq_r == QW'(q))
                    - CW'(fetch && rq_r == QW'(q));
      end
    end
  end

  // Active config capture at master reset
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcnt_r <= QCNT_RST;
      wide_in_r <= 1'b1;
      wide_out_r <= 1'b1;
      cfg_err_r <= 1'b0;
      for (int i = 0; i < QN; i++) begin
        qcfg_r[i] <= '{blocks: BLK_RST, af: AF_RST, ae: AE_RST};
      end
    end else if (mrst) begin
      wide_in_r <= wide_in_sel_i;
      wide_out_r <= wide_out_sel_i;
      cfg_err_r <= sh_sum[QN] > (BW+4)'(POOL_BLOCKS);
      // Oversized setup falls back to default
      for (int i = 0; i < QN; i++) begin
        qcfg_r[i] <= (sh_sum[QN] > (BW+4)'(POOL_BLOCKS)) ?
                     '{blocks: BLK_RST, af: AF_RST, ae: AE_RST} : qsh_r[i];
      end
      qcnt_r <= (sh_sum[QN] > (BW+4)'(POOL_BLOCKS)) ? QCNT_RST : qcnt_sh_r;
    end
  end

  // Write side: selection and half packing
  // Full rate, no idle cycles
  // Write only when selected queue not full
  assign wr_ok = wr_port_i.en && !full[wq_r] && !mrst;
  assign wr_fire = wr_ok && (wide_in_r || pend_r);
  assign wr_word = wide_in_r ? wr_port_i.data : {wr_port_i.data[HW-1:0], lo_r};

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wq_r <= '0;
      pend_r <= 1'b0;
      lo_r <= '0;
    end else begin
      if (wr_port_i.load) begin
        wq_r <= wr_port_i.qsel;
      end
      if (mrst || wr_port_i.load || prst_hit) begin
        pend_r <= 1'b0;
      end else if (wr_ok && !wide_in_r) begin
        pend_r <= !pend_r;
        if (!pend_r) begin
          lo_r <= wr_port_i.data[HW-1:0];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_fire) begin
      mem[AW'({base[wq_r], 9'h000}) + wp_r[wq_r]] <= wr_word;
    end
  end

  // Pool read at the read pointer
  assign rd_word = mem[AW'({base[rq_r], 9'h000}) + rp_r[rq_r]];

  assign consume = rd_port_i.en && valid_r;
  assign fetch = (!valid_r || (consume && !half_r)) && (cnt_r[rq_r] != '0)
                 && !mrst && !prst_hit && !rd_port_i.load;

  // Read side output register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rq_r <= '0;
      valid_r <= 1'b0;
      half_r <= 1'b0;
      hi_r <= '0;
      data_r <= '0;
    end else if (rd_port_i.load || mrst || prst_hit) begin
      if (rd_port_i.load) begin
        rq_r <= rd_port_i.qsel;
      end
      valid_r <= 1'b0;
      half_r <= 1'b0;
    end else if (fetch) begin
      data_r <= wide_out_r ? rd_word : {{HW{1'b0}}, rd_word[HW-1:0]};
      hi_r <= rd_word[WW-1:HW];
      half_r <= !wide_out_r;
      valid_r <= 1'b1;
    end else if (consume && half_r) begin
      data_r <= {{HW{1'b0}}, hi_r};
      half_r <= 1'b0;
    end else if (consume) begin
      valid_r <= 1'b0;
    end
  end

  assign read_data_o = data_r;
  assign output_valid_flag_o = valid_r;
  assign queue_full_flag_o = full[wq_r];
  assign almost_full_flag_o = afl[wq_r] && (wq_r <= qcnt_r);
  assign almost_empty_flag_o = ael[rq_r] && (rq_r <= qcnt_r);

  // APB decode and read mux
  assign acc = psel_i && penable_i;
  always_comb begin
    rd_val = '0;
    hit = 1'b0;
    if (paddr_i[1:0] == 2'b00) begin
      if (paddr_i == CTRL_OFS) begin
        hit = 1'b1;
        rd_val = 32'(qcnt_sh_r);
      end else if (paddr_i == STAT_OFS) begin
        hit = !pwrite_i;
        rd_val = {10'h000, cfg_err_r, qcnt_r, wide_out_r, wide_in_r,
                  almost_empty_status_bus_o, almost_full_status_bus_o};
      end else if (paddr_i[11:5] == QCFG_PAGE) begin
        hit = 1'b1;
        rd_val = 32'({qsh_r[paddr_i[4:2]].ae, qsh_r[paddr_i[4:2]].af,
                      qsh_r[paddr_i[4:2]].blocks});
      end else if (paddr_i[11:5] == LEVEL_PAGE) begin
        hit = !pwrite_i;
        rd_val = 32'(cnt_r[paddr_i[4:2]]);
      end
    end
  end

  // APB one wait state, registered read data
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= acc && !pready_r;
      if (acc && !pready_r && !pwrite_i) begin
        prdata_r <= hit ? rd_val : '0;
      end
    end
  end

  assign pready_o = pready_r;
  assign pslverr_o = pready_r && !hit;
  assign prdata_o = prdata_r;

  // Shadow setup written over the config port
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      qcnt_sh_r <= QCNT_RST;
      for (int i = 0; i < QN; i++) begin
        qsh_r[i] <= '{blocks: BLK_RST, af: AF_RST, ae: AE_RST};
      end
    end else if (acc && pready_r && pwrite_i && hit) begin
      if (paddr_i == CTRL_OFS) begin
        qcnt_sh_r <= pwdata_i[QW-1:0];
      end else if (paddr_i[11:5] == QCFG_PAGE) begin
        qsh_r[paddr_i[4:2]] <= '{blocks: pwdata_i[BLK_LSB +: BW],
                                 af: pwdata_i[AF_LSB +: AW],
                                 ae: pwdata_i[AE_LSB +: AW]};
      end
    end
  end
endmodule : mqfc_core

// [src/mqfc_pkg.sv]
package mqfc_pkg;
  // Queue and pool geometry
  localparam int QN = 8;
  localparam int QW = 3;
  localparam int WW = 18;
  localparam int HW = 9;
  localparam int BLK_SHIFT = 9;
  localparam int POOL_BLOCKS = 8;
  localparam int BW = 4;
  localparam int AW = 12;
  localparam int CW = 13;
  localparam int MEM_WORDS = 4096;
  // Register byte offsets and 32-byte page numbers
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [6:0] QCFG_PAGE = 7'h01;
  localparam logic [6:0] LEVEL_PAGE = 7'h02;
  // Queue config field positions
  localparam int BLK_LSB = 0;
  localparam int AF_LSB = 4;
  localparam int AE_LSB = 16;
  // Reset values: eight equal queues
  localparam logic [QW-1:0] QCNT_RST = 3'h7;
  localparam logic [BW-1:0] BLK_RST = 4'h1;
  localparam logic [AW-1:0] AF_RST = 12'h008;
  localparam logic [AW-1:0] AE_RST = 12'h008;

  typedef struct packed {
    logic [BW-1:0] blocks;
    logic [AW-1:0] af;
    logic [AW-1:0] ae;
  } mqfc_qcfg_t;

  typedef struct packed {
    logic en;
    logic load;
    logic [QW-1:0] qsel;
    logic [WW-1:0] data;
  } mqfc_wr_t;

  typedef struct packed {
    logic en;
    logic load;
    logic [QW-1:0] qsel;
  } mqfc_rd_t;
endpackage : mqfc_pkg

// [verification/mqfc_chk.sv]
`timescale 1ns/1ps
module mqfc_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire mqfc_pkg::mqfc_wr_t wr_port_i,
  input wire mqfc_pkg::mqfc_rd_t rd_port_i,
  input wire logic [mqfc_pkg::WW-1:0] read_data_o,
  input wire logic output_valid_flag_o,
  input wire logic queue_full_flag_o,
  input wire logic almost_full_flag_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o
);
  import mqfc_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Bus answer and read data
  chk_apb_wait: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
    else $error("bus ready not after one wait state");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("bus ready held too long");
  chk_err_zero: assert property (pready_o && pslverr_o && !pwrite_i
    |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  chk_rdata_hold: assert property (!(psel_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data changed without a read");
  // Queue flags and output register
  chk_full_af: assert property (queue_full_flag_o |-> almost_full_flag_o)
    else $error("full without almost full");
  chk_full_blocks: assert property (master_reset_n_i && partial_reset_n_i
    && queue_full_flag_o && wr_port_i.en && !wr_port_i.load && output_valid_flag_o
    && !rd_port_i.en && !rd_port_i.load |=> queue_full_flag_o)
    else $error("write to full queue changed its level");
  chk_out_hold: assert property (master_reset_n_i && partial_reset_n_i
    && output_valid_flag_o && !rd_port_i.en |=> $stable(read_data_o))
    else $error("output word changed without a read");
  chk_mr_valid: assert property (!master_reset_n_i |=> !output_valid_flag_o)
    else $error("output valid during master reset");
endmodule : mqfc_chk
bind mqfc_core mqfc_chk i_chk (.clock_i, .nrst_i, .master_reset_n_i, .partial_reset_n_i,
  .wr_port_i, .rd_port_i, .read_data_o, .output_valid_flag_o, .queue_full_flag_o,
  .almost_full_flag_o, .psel_i, .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o);

// [verification/mqfc_sink.sv]
`timescale 1ns/1ps
module mqfc_sink (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [mqfc_pkg::WW-1:0] data_i,
  output logic en_o
);
  import mqfc_pkg::*;
  logic [WW-1:0] got[$];
  // Read strobe, every other cycle when slow
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_o <= 1'b0;
    end else begin
      en_o <= !stall_i && !(slow_i && en_o);
    end
  end
  always_ff @(posedge clock_i) begin
    if (valid_i && en_o) begin
      got.push_back(data_i);
    end
  end
endmodule : mqfc_sink

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  import mqfc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, mrst_n = 1'b1, prst_n = 1'b1, psel = 1'b0, pen = 1'b0;
  logic pwr = 1'b0, stall = 1'b1, slow = 1'b0, rload = 1'b0, pready, perr, ovf, full, sink_en;
  logic win = 1'b1, wout = 1'b1, aff, aef;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000_7382;
  logic [WW-1:0] rdata;
  logic [QN-1:0] afb, aeb;
  logic [QW-1:0] rq = 3'h0;
  logic [WW-1:0] exp_q[$];
  mqfc_wr_t wp = '0;
  mqfc_rd_t rp;
  int bad_count = 0, checked = 0;
  assign rp = '{en: sink_en, load: rload, qsel: rq};
  // Clock
  always #12.5 clk = ~clk;
  mqfc_core i_dut (.clock_i(clk), .nrst_i(nrst), .master_reset_n_i(mrst_n),
    .partial_reset_n_i(prst_n), .wide_in_sel_i(win), .wide_out_sel_i(wout), .wr_port_i(wp),
    .rd_port_i(rp), .read_data_o(rdata), .output_valid_flag_o(ovf), .queue_full_flag_o(full),
    .almost_full_flag_o(aff), .almost_empty_flag_o(aef), .almost_full_status_bus_o(afb),
    .almost_empty_status_bus_o(aeb), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr));
  mqfc_sink i_sink (.clock_i(clk), .nrst_i(nrst), .stall_i(stall), .slow_i(slow),
    .valid_i(ovf), .data_i(rdata), .en_o(sink_en));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Expected status word from its fields
  function automatic logic [31:0] stat_word(input logic [QN-1:0] af, input logic [QN-1:0] ae,
    input logic wi, input logic wo, input logic [QW-1:0] qc);
    return {11'h000, qc, wo, wi, ae, af};
  endfunction : stat_word
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Wait for the slave; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Idle cycle, so a following setup never drives psel twice in one step
    @(posedge clk);
  endtask : apb
  task automatic sel(input logic [QW-1:0] w, input logic [QW-1:0] r);
    wp.load <= 1'b1;
    wp.qsel <= w;
    rload <= 1'b1;
    rq <= r;
    @(posedge clk);
    wp.load <= 1'b0;
    rload <= 1'b0;
  endtask : sel
  // Writes n words, first one all ones, keeping those taken
  task automatic put(input int n);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      v = (i == 0) ? 32'h0003_ffff : xs();
      wp.en <= 1'b1;
      wp.data <= v[WW-1:0];
      @(posedge clk);
      if (i > 0 && full === 1'b0) exp_q.push_back(wp.data);
      if (i == 0) exp_q.push_back(wp.data);
    end
    wp.en <= 1'b0;
    @(posedge clk);
  endtask : put
  // Writes n words in the latched widths; halves expected low first
  task automatic put_bm(input int n);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      v = xs();
      wp.en <= 1'b1;
      wp.data <= v[WW-1:0];
      @(posedge clk);
      if (!win) begin
        wp.data <= {v[HW-1:0], v[WW-1:HW]};
        @(posedge clk);
      end
      if (wout) begin
        exp_q.push_back(v[WW-1:0]);
      end else begin
        exp_q.push_back({9'h000, v[HW-1:0]});
        exp_q.push_back({9'h000, v[WW-1:HW]});
      end
    end
    wp.en <= 1'b0;
    @(posedge clk);
  endtask : put_bm
  task automatic drain();
    int n;
    n = 0;
    stall <= 1'b0;
    while (i_sink.got.size() < exp_q.size() && n < 5000) begin
      @(posedge clk);
      n++;
    end
    stall <= 1'b1;
    cmp(i_sink.got.size(), exp_q.size());
    foreach (exp_q[i]) cmp(i_sink.got[i], exp_q[i]);
    exp_q.delete();
    i_sink.got.delete();
  endtask : drain
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [WW-1:0] last;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    mrst_n <= 1'b0;
    @(posedge clk);
    mrst_n <= 1'b1;
    apb(1'b0, STAT_OFS, 32'h0, r, e);
    cmp(r, 32'h001f_ff00);
    apb(1'b0, 12'h020, 32'h0, r, e);
    cmp(r, 32'h0008_0081);
    apb(1'b0, 12'h100, 32'h0, r, e);
    cmp({31'h0, e}, 32'h1);
    cmp(r, 32'h0);
    apb(1'b1, STAT_OFS, 32'hffff_ffff, r, e);
    cmp({31'h0, e}, 32'h1);
    $display("registers test done");
    sel(3'h2, 3'h2);
    put(520);
    cmp({31'h0, full}, 32'h1);
    cmp({31'h0, aff}, 32'h1);
    cmp(exp_q.size(), 513);
    cmp({24'h0, afb}, 32'h04);
    slow <= 1'b1;
    drain();
    slow <= 1'b0;
    $display("fill and drain test done");
    put(10);
    cmp({24'h0, aeb}, 32'hfb);
    cmp({31'h0, aef}, 32'h0);
    prst_n <= 1'b0;
    @(posedge clk);
    prst_n <= 1'b1;
    @(posedge clk);
    cmp({24'h0, aeb}, 32'hff);
    cmp({31'h0, aef}, 32'h1);
    cmp({31'h0, ovf}, 32'h0);
    exp_q.delete();
    sel(3'h5, 3'h2);
    put(10);
    prst_n <= 1'b0;
    @(posedge clk);
    prst_n <= 1'b1;
    @(posedge clk);
    cmp({24'h0, aeb}, 32'hdf);
    cmp({31'h0, ovf}, 32'h0);
    last = exp_q[exp_q.size() - 1];
    sel(3'h5, 3'h5);
    drain();
    sel(3'h5, 3'h2);
    @(posedge clk);
    cmp(rdata, last);
    $display("partial reset and reselect test done");
    // Two queues of four blocks, applied with narrow input
    sel(3'h1, 3'h1);
    apb(1'b1, CTRL_OFS, 32'h0000_0001, r, e);
    cmp({31'h0, e}, 32'h0);
    apb(1'b1, 12'h020, 32'h0008_0084, r, e);
    apb(1'b1, 12'h024, 32'h0008_0084, r, e);
    win <= 1'b0;
    mrst_n <= 1'b0;
    @(posedge clk);
    mrst_n <= 1'b1;
    apb(1'b0, STAT_OFS, 32'h0, r, e);
    cmp(r, stat_word(8'h00, 8'h03, 1'b0, 1'b1, 3'h1));
    put_bm(6);
    apb(1'b0, 12'h044, 32'h0, r, e);
    cmp(r, 32'h0000_0005);
    drain();
    win <= 1'b1;
    wout <= 1'b0;
    mrst_n <= 1'b0;
    @(posedge clk);
    mrst_n <= 1'b1;
    put_bm(6);
    drain();
    $display("bus matching test done");
    tally_and_finish();
  end
endmodule : tb
